// file: rtl/drive_fault_alarm_manager.v
// Fault, warning and stop-reaction manager for a servo drive.
`timescale 1ns/100ps
`include "fault_mgr_consts.vh"

// What this block does
// RULE1: Status bit 3 set while fault active.
// RULE2: Each new fault written to fault log.
// RULE3: Each fault starts its configured stop reaction.
// RULE4: Status bit 7 set on any warning.
// RULE5: Warnings logged in separate warning log.
// RULE6: Warnings clear themselves when cause disappears.
// RULE7: Fault clears only when cause gone and acknowledged.
// RULE8: Coast stop: pulses off, brake, power-on inhibit.
// RULE9: Ramp stop: zero setpoint, ramp, brake, then inhibit.
// RULE10: Zero speed by threshold or timer expiry.
// RULE11: Ramp hold: zero setpoint, keep pulses enabled.
// RULE12: Power-cycle faults clear only by power-on.
// RULE13: Acknowledge parameter 0-to-1 acknowledges immediate faults.
// RULE14: Three acknowledge inputs also acknowledge.
// RULE15: Control word bit 7 rising edge acknowledges.
// RULE16: Immediate faults also clear by power-on.
// RULE17: Safety faults need safe standstill deselected first.
// RULE18: Ready-class faults acknowledge only in ready state.
// RULE19: Each message typed; safety messages own buffer.
// RULE20: Selectable type picks its reaction and class; ALT_ACK_CLASS reaches no output, ALT_REACT only a fault still active once typed alarm.
// RULE21: Display code is 2 before five-digit number.
// RULE22: All acknowledge sources edge-detected and ORed.
module drive_fault_alarm_manager #(
    parameter N = 8,
    parameter LOG_DEPTH = 8,
    parameter LOG_AW = 3,
    parameter BRAKE_CYC = `BRAKE_APPLY_CYC,
    parameter ZERO_TO_CYC = `ZERO_TIMEOUT_CYC,
    parameter CW = 24
) (
    input wire SYS_CLK,
    input wire SYS_RST,
    input wire [N-1:0] CAUSE,
    input wire [2*N-1:0] MSG_TYPE,
    input wire [2*N-1:0] FAULT_REACT,
    input wire [2*N-1:0] FAULT_ACK_CLASS,
    input wire [2*N-1:0] ALT_REACT,
    input wire [2*N-1:0] ALT_ACK_CLASS,
    input wire [N-1:0] SAFETY_SOURCE,
    input wire [20*N-1:0] MSG_NUMBER,
    input wire ACK_PARAM,
    input wire ACK_INPUT_FIRST,
    input wire ACK_INPUT_SECOND,
    input wire ACK_INPUT_THIRD,
    input wire [15:0] DRIVE_CONTROL_WORD,
    input wire SAFE_STANDSTILL,
    input wire READY_STATE,
    input wire BRAKE_CONFIGURED,
    input wire SETPOINT_AT_ZERO,
    input wire SPEED_BELOW_THRESHOLD,
    output reg [15:0] DRIVE_STATUS_WORD,
    output reg [N-1:0] FAULT_ACTIVE,
    output reg [N-1:0] WARN_ACTIVE,
    output reg PULSE_INHIBIT,
    output reg BRAKE_CLOSE,
    output reg POWER_ON_INHIBIT,
    output reg FORCE_ZERO_SETPOINT,
    output reg USE_DOWN_RAMP,
    output reg ZERO_SPEED,
    output reg [2:0] STOP_STATE,
    output reg [LOG_AW:0] FAULT_LOG_COUNT,
    output reg [LOG_AW:0] WARN_LOG_COUNT,
    output reg [LOG_AW:0] SAFETY_LOG_COUNT,
    output reg [LOG_AW-1:0] RD_INDEX,
    input wire [1:0] RD_SELECT,
    input wire [LOG_AW-1:0] RD_ADDR,
    output reg [CW-1:0] RD_CODE
);

    // Three-stage synchronisers for the acknowledge inputs and the causes; stage one feeds stage two only.
    reg [4:0] s1_q, s2_q, s3_q;
    reg [4:0] agreed_q;
    reg [N-1:0] c1_q, c2_q, c3_q, cause_q;
    wire [4:0] raw_in = {DRIVE_CONTROL_WORD[`CTRL_ACK_BIT], ACK_INPUT_THIRD, ACK_INPUT_SECOND,
                         ACK_INPUT_FIRST, ACK_PARAM};
    wire [4:0] rise = (s2_q & s3_q) & ~agreed_q;
    reg ack_q;
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            s1_q <= 5'h00;
            s2_q <= 5'h00;
            s3_q <= 5'h00;
            agreed_q <= 5'h00;
            c1_q <= {N{1'b0}};
            c2_q <= {N{1'b0}};
            c3_q <= {N{1'b0}};
            cause_q <= {N{1'b0}};
            ack_q <= 1'b0;
        end else begin
            s1_q <= raw_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            agreed_q <= (s2_q & s3_q) | (agreed_q & (s2_q | s3_q));
            c1_q <= CAUSE;
            c2_q <= c1_q;
            c3_q <= c2_q;
            cause_q <= (c2_q & c3_q) | (cause_q & (c2_q | c3_q));
            ack_q <= |rise; // see RULE13 see RULE14 see RULE15 see RULE22
        end
    end

    // Per-message effective type, reaction and acknowledge class.
    reg [N-1:0] safe_seen_q;
    wire [N-1:0] is_fault, is_warn, is_safe, ack_ok, new_fault, new_warn, new_safe;
    wire [2*N-1:0] eff_react;
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : msg
            wire [1:0] ty = MSG_TYPE[2*g+1:2*g];
            wire alt = (ty == `TYPE_ALARM);
            wire [1:0] cls = alt ? ALT_ACK_CLASS[2*g+1:2*g] : FAULT_ACK_CLASS[2*g+1:2*g]; // see RULE20
            assign eff_react[2*g+1:2*g] = alt ? ALT_REACT[2*g+1:2*g] : FAULT_REACT[2*g+1:2*g];
            assign is_fault[g] = (ty == `TYPE_FAULT);
            assign is_warn[g] = (ty == `TYPE_ALARM);
            assign is_safe[g] = (ty == `TYPE_SAFETY); // see RULE19
            assign ack_ok[g] = ack_q && !cause_q[g] && (cls != `ACK_POWER) // see RULE7 see RULE12
                && !(SAFETY_SOURCE[g] && SAFE_STANDSTILL) // see RULE17
                && ((cls != `ACK_READY) || READY_STATE); // see RULE18
            assign new_fault[g] = cause_q[g] && is_fault[g] && !FAULT_ACTIVE[g];
            assign new_warn[g] = cause_q[g] && is_warn[g] && !WARN_ACTIVE[g];
            assign new_safe[g] = cause_q[g] && is_safe[g] && !safe_seen_q[g];
        end
    endgenerate

    // Lowest-numbered new event of each kind is logged this cycle.
    function [LOG_AW+7:0] first_set;
        input [N-1:0] v;
        integer i;
        begin
            first_set = {(LOG_AW+8){1'b0}};
            for (i = N - 1; i >= 0; i = i - 1) begin
                if (v[i]) begin
                    first_set = {1'b1, i[LOG_AW+6:0]};
                end
            end
        end
    endfunction
    wire [LOG_AW+7:0] pf = first_set(new_fault);
    wire [LOG_AW+7:0] pw = first_set(new_warn);
    wire [LOG_AW+7:0] ps = first_set(new_safe);
    wire [N-1:0] fault_log_mask = pf[LOG_AW+7] ? ({{(N-1){1'b0}}, 1'b1} << pf[LOG_AW+6:0]) : {N{1'b0}};
    wire [N-1:0] warn_log_mask = pw[LOG_AW+7] ? ({{(N-1){1'b0}}, 1'b1} << pw[LOG_AW+6:0]) : {N{1'b0}};
    wire [N-1:0] safe_log_mask = ps[LOG_AW+7] ? ({{(N-1){1'b0}}, 1'b1} << ps[LOG_AW+6:0]) : {N{1'b0}};
    // Next fault flags, shared so the status bit never lags a cleared fault.
    wire [N-1:0] fault_next = fault_log_mask | (FAULT_ACTIVE & ~(ack_ok & is_fault)) | (FAULT_ACTIVE & ~is_fault);

    // Log memories hold display codes: a leading 2 before the message number.
    reg [CW-1:0] fault_log [0:LOG_DEPTH-1];
    reg [CW-1:0] warn_log [0:LOG_DEPTH-1];
    reg [CW-1:0] safe_log [0:LOG_DEPTH-1];
    reg [LOG_AW-1:0] fwp_q, wwp_q, swp_q;
    function [CW-1:0] disp_code;
        input [19:0] num;
        begin
            disp_code = `DISPLAY_PREFIX | {4'h0, num}; // see RULE21
        end
    endfunction

    always @(posedge SYS_CLK) begin
        if (pf[LOG_AW+7]) begin
            fault_log[fwp_q] <= disp_code(MSG_NUMBER[20*pf[LOG_AW+6:0] +: 20]); // see RULE2
        end
        if (pw[LOG_AW+7]) begin
            warn_log[wwp_q] <= disp_code(MSG_NUMBER[20*pw[LOG_AW+6:0] +: 20]); // see RULE5
        end
        if (ps[LOG_AW+7]) begin
            safe_log[swp_q] <= disp_code(MSG_NUMBER[20*ps[LOG_AW+6:0] +: 20]); // see RULE19
        end
    end

    // Active flags; a new cause wins over an acknowledge in the same cycle.
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            FAULT_ACTIVE <= {N{1'b0}}; // see RULE12 see RULE16
            WARN_ACTIVE <= {N{1'b0}};
            safe_seen_q <= {N{1'b0}};
            fwp_q <= {LOG_AW{1'b0}};
            wwp_q <= {LOG_AW{1'b0}};
            swp_q <= {LOG_AW{1'b0}};
            FAULT_LOG_COUNT <= {(LOG_AW+1){1'b0}};
            WARN_LOG_COUNT <= {(LOG_AW+1){1'b0}};
            SAFETY_LOG_COUNT <= {(LOG_AW+1){1'b0}};
            RD_INDEX <= {LOG_AW{1'b0}};
        end else begin
            FAULT_ACTIVE <= fault_next; // see RULE7
            WARN_ACTIVE <= warn_log_mask | (WARN_ACTIVE & cause_q & is_warn); // see RULE6
            safe_seen_q <= safe_log_mask | (safe_seen_q & cause_q);
            if (pf[LOG_AW+7]) begin
                fwp_q <= fwp_q + 1'b1;
                RD_INDEX <= fwp_q;
                if (FAULT_LOG_COUNT != LOG_DEPTH) begin
                    FAULT_LOG_COUNT <= FAULT_LOG_COUNT + 1'b1;
                end
            end
            if (pw[LOG_AW+7]) begin
                wwp_q <= wwp_q + 1'b1;
                if (WARN_LOG_COUNT != LOG_DEPTH) begin
                    WARN_LOG_COUNT <= WARN_LOG_COUNT + 1'b1;
                end
            end
            if (ps[LOG_AW+7]) begin
                swp_q <= swp_q + 1'b1;
                if (SAFETY_LOG_COUNT != LOG_DEPTH) begin
                    SAFETY_LOG_COUNT <= SAFETY_LOG_COUNT + 1'b1;
                end
            end
        end
    end

    // Log read port, one cycle latency.
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            RD_CODE <= {CW{1'b0}};
        end else begin
            case (RD_SELECT)
                2'h0: RD_CODE <= fault_log[RD_ADDR];
                2'h1: RD_CODE <= warn_log[RD_ADDR];
                2'h2: RD_CODE <= safe_log[RD_ADDR];
                default: RD_CODE <= {CW{1'b0}};
            endcase
        end
    end

    // Strongest reaction among active faults: coast over ramp over hold.
    reg want_coast, want_ramp, want_hold;
    integer k;
    always @* begin
        want_coast = 1'b0;
        want_ramp = 1'b0;
        want_hold = 1'b0;
        for (k = 0; k < N; k = k + 1) begin
            if (FAULT_ACTIVE[k] || fault_log_mask[k]) begin
                want_coast = want_coast | (eff_react[2*k +: 2] == `REACT_COAST);
                want_ramp = want_ramp | (eff_react[2*k +: 2] == `REACT_RAMP);
                want_hold = want_hold | (eff_react[2*k +: 2] == `REACT_HOLD);
            end
        end
    end

    // Zero-speed detection: threshold, or timer from setpoint at zero.
    reg [31:0] zero_cnt_q;
    wire zero_now = SPEED_BELOW_THRESHOLD || (zero_cnt_q >= ZERO_TO_CYC); // see RULE10
    reg [31:0] brake_cnt_q;

    // Stop reaction state machine.
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            STOP_STATE <= `STOP_IDLE;
            zero_cnt_q <= 32'h00000000;
            brake_cnt_q <= 32'h00000000;
            ZERO_SPEED <= 1'b0;
            PULSE_INHIBIT <= 1'b0;
            BRAKE_CLOSE <= 1'b0;
            POWER_ON_INHIBIT <= 1'b0;
            FORCE_ZERO_SETPOINT <= 1'b0;
            USE_DOWN_RAMP <= 1'b0;
            DRIVE_STATUS_WORD <= 16'h0000;
        end else begin
            DRIVE_STATUS_WORD[`STAT_FAULT_BIT] <= |fault_next; // see RULE1
            DRIVE_STATUS_WORD[`STAT_WARN_BIT] <= |(cause_q & is_warn); // see RULE4
            ZERO_SPEED <= zero_now;
            if (SETPOINT_AT_ZERO && FORCE_ZERO_SETPOINT) begin
                zero_cnt_q <= (zero_cnt_q >= ZERO_TO_CYC) ? zero_cnt_q : zero_cnt_q + 32'h1;
            end else begin
                zero_cnt_q <= 32'h00000000;
            end
            case (STOP_STATE)
                `STOP_IDLE: begin
                    PULSE_INHIBIT <= 1'b0;
                    BRAKE_CLOSE <= 1'b0;
                    FORCE_ZERO_SETPOINT <= 1'b0;
                    USE_DOWN_RAMP <= 1'b0;
                    if (want_coast) begin
                        STOP_STATE <= `STOP_COAST; // see RULE3
                        PULSE_INHIBIT <= 1'b1; // see RULE8
                        BRAKE_CLOSE <= BRAKE_CONFIGURED;
                        POWER_ON_INHIBIT <= 1'b1;
                    end else if (want_ramp) begin
                        STOP_STATE <= `STOP_RAMP;
                        FORCE_ZERO_SETPOINT <= 1'b1; // see RULE9
                        USE_DOWN_RAMP <= 1'b1;
                    end else if (want_hold) begin
                        STOP_STATE <= `STOP_HOLD;
                        FORCE_ZERO_SETPOINT <= 1'b1; // see RULE11
                        USE_DOWN_RAMP <= 1'b1;
                    end else if (!SAFE_STANDSTILL) begin
                        POWER_ON_INHIBIT <= 1'b0;
                    end
                end
                `STOP_RAMP: begin
                    if (want_coast) begin
                        STOP_STATE <= `STOP_IDLE;
                    end else if (zero_now) begin
                        STOP_STATE <= `STOP_BRAKE;
                        BRAKE_CLOSE <= BRAKE_CONFIGURED; // see RULE9
                        brake_cnt_q <= 32'h00000000;
                    end
                end
                `STOP_BRAKE: begin
                    if (brake_cnt_q + 32'h1 >= BRAKE_CYC) begin
                        PULSE_INHIBIT <= 1'b1; // see RULE9
                        STOP_STATE <= `STOP_COAST;
                    end else begin
                        brake_cnt_q <= brake_cnt_q + 32'h1;
                    end
                end
                `STOP_HOLD: begin
                    if (want_coast || want_ramp || !want_hold) begin
                        STOP_STATE <= `STOP_IDLE; // see RULE11
                    end
                end
                `STOP_COAST: begin
                    if (!(want_coast || want_ramp || want_hold)) begin
                        STOP_STATE <= `STOP_IDLE;
                    end
                end
                default: STOP_STATE <= `STOP_IDLE;
            endcase
        end
    end

endmodule

// file: rtl/fault_mgr_consts.vh
// Constants for the drive fault and alarm manager.
`ifndef FAULT_MGR_CONSTS_VH
`define FAULT_MGR_CONSTS_VH
`define STAT_FAULT_BIT 3
`define STAT_WARN_BIT 7
`define CTRL_ACK_BIT 7
`define TYPE_ALARM 2'h0
`define TYPE_FAULT 2'h1
`define TYPE_NONE 2'h2
`define TYPE_SAFETY 2'h3
`define REACT_NONE 2'h0
`define REACT_COAST 2'h1
`define REACT_RAMP 2'h2
`define REACT_HOLD 2'h3
`define ACK_IMMEDIATE 2'h0
`define ACK_POWER 2'h1
`define ACK_READY 2'h2
`define DISPLAY_PREFIX 24'h200000
`define CLK_HZ 20000000
`define BRAKE_APPLY_MS 100
`define BRAKE_APPLY_CYC ((`BRAKE_APPLY_MS * (`CLK_HZ / 1000)))
`define ZERO_TIMEOUT_MS 200
`define ZERO_TIMEOUT_CYC ((`ZERO_TIMEOUT_MS * (`CLK_HZ / 1000)))
`define STOP_IDLE 3'h0
`define STOP_COAST 3'h1
`define STOP_RAMP 3'h2
`define STOP_BRAKE 3'h3
`define STOP_HOLD 3'h4
`endif

// file: tb/fault_mgr_sva.sv
// Port-level checker for the drive fault and alarm manager.
`timescale 1ns/100ps
module fault_mgr_sva #(
    parameter N = 8,
    parameter LOG_DEPTH = 8,
    parameter LOG_AW = 3
) (
    input wire SYS_CLK,
    input wire SYS_RST,
    input wire [N-1:0] CAUSE,
    input wire BRAKE_CONFIGURED,
    input wire [15:0] DRIVE_STATUS_WORD,
    input wire [N-1:0] FAULT_ACTIVE,
    input wire [N-1:0] WARN_ACTIVE,
    input wire PULSE_INHIBIT,
    input wire BRAKE_CLOSE,
    input wire POWER_ON_INHIBIT,
    input wire FORCE_ZERO_SETPOINT,
    input wire USE_DOWN_RAMP,
    input wire [2:0] STOP_STATE,
    input wire [LOG_AW:0] FAULT_LOG_COUNT
);
    localparam int BRK_LO = 8;
    localparam int BRK_HI = 12;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    // Status bits, stop outputs and logging tied to their causes.
    property p_stat_fault; DRIVE_STATUS_WORD[3] == (|FAULT_ACTIVE); endproperty
    property p_stat_warn; DRIVE_STATUS_WORD[7] == (|WARN_ACTIVE); endproperty
    property p_coast; $rose(STOP_STATE == 3'h1) && $past(STOP_STATE) == 3'h0
        |-> PULSE_INHIBIT && POWER_ON_INHIBIT && (BRAKE_CLOSE || !BRAKE_CONFIGURED); endproperty
    property p_ramp; STOP_STATE == 3'h2 |-> FORCE_ZERO_SETPOINT && USE_DOWN_RAMP && !PULSE_INHIBIT; endproperty
    property p_hold; STOP_STATE == 3'h4 |-> FORCE_ZERO_SETPOINT && !PULSE_INHIBIT; endproperty
    property p_brake; $rose(STOP_STATE == 3'h3) |-> BRAKE_CLOSE ##[BRK_LO:BRK_HI] STOP_STATE == 3'h1 && PULSE_INHIBIT;
    endproperty
    property p_warn_clear; CAUSE == '0 [*6] |-> WARN_ACTIVE == '0; endproperty
    property p_fault_stays; (CAUSE[0] && FAULT_ACTIVE[0]) [*5] |=> FAULT_ACTIVE[0]; endproperty
    property p_log; $rose(FAULT_ACTIVE[0])
        |-> FAULT_LOG_COUNT == $past(FAULT_LOG_COUNT) + 1 || $past(FAULT_LOG_COUNT) == LOG_DEPTH; endproperty
    a_stat_fault: assert property (p_stat_fault) else $error("fault status bit wrong");
    a_stat_warn: assert property (p_stat_warn) else $error("warning status bit wrong");
    a_coast: assert property (p_coast) else $error("coast outputs wrong");
    a_ramp: assert property (p_ramp) else $error("ramp outputs wrong");
    a_hold: assert property (p_hold) else $error("hold outputs wrong");
    a_brake: assert property (p_brake) else $error("brake wait span wrong");
    a_warn_clear: assert property (p_warn_clear) else $error("warning did not clear");
    a_fault_stays: assert property (p_fault_stays) else $error("fault cleared with cause");
    a_log: assert property (p_log) else $error("fault not logged");
    c_hold: cover property (STOP_STATE == 3'h4);
    c_brake: cover property (STOP_STATE == 3'h3);
    c_clear: cover property ($fell(FAULT_ACTIVE[0]));
endmodule
bind drive_fault_alarm_manager fault_mgr_sva #(.N(N), .LOG_DEPTH(LOG_DEPTH), .LOG_AW(LOG_AW)) u_sva (.*);

// file: tb/fieldbus_ctrl_model.sv
// Behavioural higher-level controller driving the fieldbus control word.
`timescale 1ns/100ps
module fieldbus_ctrl_model #(
    parameter logic [15:0] BASE_WORD = 16'h0006
) (
    input wire SYS_CLK,
    input wire ack_req,
    output logic [15:0] ctrl_word
);
    // The acknowledge bit follows the request and only moves on the falling edge.
    always @(negedge SYS_CLK) begin
        ctrl_word <= {BASE_WORD[15:8], ack_req, BASE_WORD[6:0]};
    end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the drive fault and alarm manager.
`timescale 1ns/100ps
`include "fault_mgr_consts.vh"
module tb_top;
    localparam N = 2;
    reg SYS_CLK, SYS_RST, ACK_PARAM, ACK_INPUT_FIRST, ACK_INPUT_SECOND, ACK_INPUT_THIRD, ack_cw;
    reg SAFE_STANDSTILL, READY_STATE, SETPOINT_AT_ZERO, SPEED_BELOW_THRESHOLD, BRAKE_CONFIGURED;
    reg [N-1:0] CAUSE, SAFETY_SOURCE;
    reg [2*N-1:0] MSG_TYPE, FAULT_REACT, FAULT_ACK_CLASS, ALT_REACT, ALT_ACK_CLASS;
    reg [20*N-1:0] MSG_NUMBER;
    reg [1:0] RD_SELECT;
    reg [2:0] RD_ADDR;
    wire [15:0] DRIVE_CONTROL_WORD, DRIVE_STATUS_WORD;
    wire [N-1:0] FAULT_ACTIVE, WARN_ACTIVE;
    wire PULSE_INHIBIT, BRAKE_CLOSE, POWER_ON_INHIBIT, FORCE_ZERO_SETPOINT, USE_DOWN_RAMP, ZERO_SPEED;
    wire [2:0] STOP_STATE, RD_INDEX;
    wire [3:0] FAULT_LOG_COUNT, WARN_LOG_COUNT, SAFETY_LOG_COUNT;
    wire [23:0] RD_CODE;
    int n_errors, check_count, n, exp_flog;
    drive_fault_alarm_manager #(.N(N), .BRAKE_CYC(10), .ZERO_TO_CYC(20)) u_dut (.*);
    fieldbus_ctrl_model u_ctrl (.SYS_CLK(SYS_CLK), .ack_req(ack_cw), .ctrl_word(DRIVE_CONTROL_WORD));
    // Prints the counts and the verdict, then stops the run.
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Compares one observed value with its expectation.
    task check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Waits a bounded time for a fault, a warning or the inhibited stop state.
    task wt(input int k, input logic v);
        logic cur;
        for (n = 0; n < 60; n++) begin
            cur = k == 0 ? FAULT_ACTIVE[0] : k == 1 ? WARN_ACTIVE[1] : STOP_STATE == 3'h1;
            if (cur === v) return;
            @(negedge SYS_CLK);
        end
        check("wait bound", n, 0);
        print_verdict;
    endtask
    // Gives one acknowledge edge from the chosen source, long enough to pass the synchronisers.
    task ack(input int s);
        @(negedge SYS_CLK);
        case (s)
            0: ACK_PARAM = 1'b1;
            1: ACK_INPUT_FIRST = 1'b1;
            2: ACK_INPUT_SECOND = 1'b1;
            3: ACK_INPUT_THIRD = 1'b1;
            default: ack_cw = 1'b1;
        endcase
        repeat (8) @(negedge SYS_CLK);
        {ACK_PARAM, ACK_INPUT_FIRST, ACK_INPUT_SECOND, ACK_INPUT_THIRD, ack_cw} = '0;
        repeat (8) @(negedge SYS_CLK);
    endtask
    // Raises fault 0, checks the reaction, then acknowledges with and without its cause.
    task fault_cycle(input logic [1:0] rc, input logic [1:0] cl, input int s, input logic clr);
        FAULT_REACT[1:0] = rc;
        FAULT_ACK_CLASS[1:0] = cl;
        CAUSE[0] = 1'b1;
        wt(0, 1'b1);
        if (exp_flog < 8) exp_flog++;
        check("status fault bit", DRIVE_STATUS_WORD[3], 1);
        check("fault log count", FAULT_LOG_COUNT, exp_flog);
        check("last fault slot", RD_INDEX, (exp_flog - 1) % 8);
        check("stop state", STOP_STATE, rc == 2'h1 ? 1 : rc == 2'h2 ? 2 : 4);
        if (rc == 2'h1) check("coast outputs", {PULSE_INHIBIT, BRAKE_CLOSE, POWER_ON_INHIBIT}, 3'h7);
        if (rc == 2'h3) check("hold outputs", {PULSE_INHIBIT, FORCE_ZERO_SETPOINT}, 2'h1);
        if (rc == 2'h2 && !SPEED_BELOW_THRESHOLD) begin
            check("early zero speed", ZERO_SPEED, 0);
            wt(2, 1'b1);
            check("ramp span", n >= 28 && n <= 34, 1);
        end
        ack(s);
        check("ack with cause", FAULT_ACTIVE[0], 1);
        CAUSE[0] = 1'b0;
        repeat (6) @(negedge SYS_CLK);
        ack(s);
        check("fault after ack", FAULT_ACTIVE[0], !clr);
    endtask
    initial begin
        SYS_CLK = 1'b0;
        forever #25 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        SYS_RST = 1'b1;
        {ACK_PARAM, ACK_INPUT_FIRST, ACK_INPUT_SECOND, ACK_INPUT_THIRD, ack_cw} = '0;
        {SAFE_STANDSTILL, READY_STATE, SETPOINT_AT_ZERO, SPEED_BELOW_THRESHOLD, BRAKE_CONFIGURED} = 5'h0f;
        {CAUSE, SAFETY_SOURCE, FAULT_REACT, FAULT_ACK_CLASS, ALT_REACT, ALT_ACK_CLASS} = '0;
        MSG_TYPE = {`TYPE_ALARM, `TYPE_FAULT};
        MSG_NUMBER = {20'h00042, 20'h12345};
        {RD_SELECT, RD_ADDR} = 5'h08;
        repeat (5) @(negedge SYS_CLK);
        SYS_RST = 1'b0;
        CAUSE[1] = 1'b1;
        wt(1, 1'b1);
        check("status warn bit", DRIVE_STATUS_WORD[7], 1);
        check("warn and fault logs", {WARN_LOG_COUNT, FAULT_LOG_COUNT}, 8'h10);
        CAUSE[1] = 1'b0;
        wt(1, 1'b0);
        check("status after warning", DRIVE_STATUS_WORD, 0);
        repeat (2) @(negedge SYS_CLK);
        check("display code", RD_CODE, 24'h200042);
        MSG_TYPE[3:2] = `TYPE_SAFETY;
        CAUSE[1] = 1'b1;
        repeat (8) @(negedge SYS_CLK);
        check("safety log", {SAFETY_LOG_COUNT, WARN_ACTIVE, FAULT_ACTIVE}, 8'h10);
        CAUSE[1] = 1'b0;
        repeat (8) @(negedge SYS_CLK);
        $display("warning test done");
        for (int i = 0; i < 5; i++) fault_cycle(2'(i % 3 + 1), 2'h0, i, 1'b1);
        $display("acknowledge source test done");
        READY_STATE = 1'b0;
        fault_cycle(2'h1, 2'h2, 0, 1'b0);
        READY_STATE = 1'b1;
        ack(0);
        check("ready state ack", FAULT_ACTIVE[0], 0);
        SAFETY_SOURCE = 2'h1;
        SAFE_STANDSTILL = 1'b1;
        fault_cycle(2'h1, 2'h0, 1, 1'b0);
        SAFE_STANDSTILL = 1'b0;
        ack(1);
        check("standstill ack", FAULT_ACTIVE[0], 0);
        SAFETY_SOURCE = 2'h0;
        fault_cycle(2'h1, 2'h1, 2, 1'b0);
        CAUSE[0] = 1'b1;
        SYS_RST = 1'b1;
        repeat (5) @(negedge SYS_CLK);
        SYS_RST = 1'b0;
        exp_flog = 0;
        wt(0, 1'b1);
        check("raised after power on", FAULT_ACTIVE[0], 1);
        CAUSE[0] = 1'b0;
        FAULT_ACK_CLASS[1:0] = 2'h0;
        SYS_RST = 1'b1;
        repeat (5) @(negedge SYS_CLK);
        SYS_RST = 1'b0;
        repeat (8) @(negedge SYS_CLK);
        check("cleared by power on", FAULT_ACTIVE, 0);
        $display("refusal and power-on test done");
        SPEED_BELOW_THRESHOLD = 1'b0;
        fault_cycle(2'h2, 2'h0, 4, 1'b1);
        RD_SELECT = 2'h0;
        repeat (2) @(negedge SYS_CLK);
        check("fault log code", RD_CODE, 24'h212345);
        $display("ramp timer test done");
        print_verdict;
    end
endmodule
